// >>> sxs_defs.svh
`ifndef SXS_DEFS_SVH
`define SXS_DEFS_SVH

// ******************************************************
// register map (byte addresses on the bus)
// ******************************************************
`define SXS_ADR_W 12
`define SXS_ADR_ACC 12'h000
`define SXS_ADR_STATUS 12'h004
`define SXS_ADR_CMD 12'h008
`define SXS_MEM_HI 3'h1

// ******************************************************
// field positions
// ******************************************************
`define SXS_ST_C 0
`define SXS_ST_DC 1
`define SXS_ST_Z 2
`define SXS_CMD_DEST 11
`define SXS_CMD_OP_HI 10
`define SXS_CMD_OP_LO 8
`define SXS_CMD_W 12

// ******************************************************
// sizes and reset values
// ******************************************************
`define SXS_FILE_AW 7
`define SXS_FILE_DEPTH 128
`define SXS_ACC_RST 8'h00
`define SXS_CMD_RST 12'h000

`endif

// >>> sxs_pkg.sv
package sxs_pkg;

   typedef enum logic [2:0] {
      OP_SUB_ACC_FROM_LITERAL = 3'h0,
      OP_SUB_ACC_FROM_FILE = 3'h1,
      OP_XOR_ACC_WITH_FILE = 3'h2,
      OP_NIBBLE_EXCHANGE_FILE = 3'h3,
      OP_XOR_LITERAL_INTO_ACC = 3'h4,
      OP_RSVD5 = 3'h5,
      OP_RSVD6 = 3'h6,
      OP_RSVD7 = 3'h7
   } sxs_op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_FETCH = 3'h2,
      ST_EXEC = 3'h4
   } sxs_state_t;

endpackage

// >>> sxs_file_ram.sv
`timescale 1ns/1ps
`include "sxs_defs.svh"

module sxs_file_ram (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [`SXS_FILE_AW-1:0] adr_i,
   input wire logic [7:0] wdat_i,
   output logic [7:0] rdat_o
);
   // no reset on the array; contents are unknown until written
   logic [7:0] mem [0:`SXS_FILE_DEPTH-1];
   logic [7:0] rdat_q;

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[adr_i] <= wdat_i;
      end
      rdat_q <= mem[adr_i];
   end

   assign rdat_o = rdat_q;
endmodule

// >>> sxs_alu_core.sv
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "sxs_defs.svh"
module sxs_alu_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`SXS_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic busy_o
);
   import sxs_pkg::*;

   // ******************************************************
   // bus slave
   // ******************************************************
   logic pend_q;
   logic ack_q;
   logic [31:0] dat_q;
   sxs_state_t st_q;
   sxs_state_t st_d;
   logic [7:0] acc_q;
   logic [7:0] acc_d;
   logic c_q;
   logic c_d;
   logic dc_q;
   logic dc_d;
   logic z_q;
   logic z_d;
   logic [`SXS_CMD_W-1:0] cmd_q;
   logic [7:0] mem_rdat;

   // requests wait while an operation runs; the file array has one port
   wire req_w = wb_cyc_i & wb_stb_i & ~ack_q & ~pend_q & (st_q == ST_IDLE);
   // writes land on the ack edge, the one edge the master commits to
   wire wr_w = ack_q & wb_cyc_i & wb_stb_i & wb_we_i;
   wire sel_acc = (wb_adr_i == `SXS_ADR_ACC);
   wire sel_st = (wb_adr_i == `SXS_ADR_STATUS);
   wire sel_cmd = (wb_adr_i == `SXS_ADR_CMD);
   wire sel_mem = (wb_adr_i[11:9] == `SXS_MEM_HI);
   wire wr_acc = wr_w & sel_acc & wb_sel_i[0];
   wire wr_st = wr_w & sel_st & wb_sel_i[0];
   wire wr_cmd = wr_w & sel_cmd & (&wb_sel_i[1:0]);
   wire wr_mem = wr_w & sel_mem & wb_sel_i[0];
   wire [31:0] rd_mux = sel_acc ? {24'h000000, acc_q} :
                        sel_st ? {29'h0, z_q, dc_q, c_q} :
                        sel_cmd ? {20'h00000, cmd_q} :
                        sel_mem ? {24'h000000, mem_rdat} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         pend_q <= req_w;
         ack_q <= pend_q;
         if (pend_q) begin
            dat_q <= rd_mux;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign busy_o = (st_q != ST_IDLE);

   // ******************************************************
   // operand and result datapath
   // ******************************************************
   wire sxs_op_t op_w = sxs_op_t'(cmd_q[`SXS_CMD_OP_HI:`SXS_CMD_OP_LO]);
   wire dest_w = cmd_q[`SXS_CMD_DEST];
   wire [`SXS_FILE_AW-1:0] fadr_w = cmd_q[`SXS_FILE_AW-1:0];
   wire is_file = (op_w == OP_SUB_ACC_FROM_FILE) |
                  (op_w == OP_XOR_ACC_WITH_FILE) |
                  (op_w == OP_NIBBLE_EXCHANGE_FILE);
   wire is_sub = (op_w == OP_SUB_ACC_FROM_LITERAL) |
                 (op_w == OP_SUB_ACC_FROM_FILE);
   wire is_xor = (op_w == OP_XOR_ACC_WITH_FILE) |
                 (op_w == OP_XOR_LITERAL_INTO_ACC);
   wire is_swp = (op_w == OP_NIBBLE_EXCHANGE_FILE);
   wire op_ok = is_sub | is_xor | is_swp;
   wire [7:0] opnd_w = is_file ? mem_rdat : cmd_q[7:0];
   wire [7:0] sub_w = opnd_w - acc_q;
   wire [7:0] xor_w = acc_q ^ opnd_w;
   wire [7:0] swp_w = {opnd_w[3:0], opnd_w[7:4]};
   wire [7:0] res_w = is_sub ? sub_w : (is_xor ? xor_w : swp_w);
   wire exec_w = (st_q == ST_EXEC);
   wire to_file = exec_w & is_file & dest_w;
   wire to_acc = exec_w & op_ok & ~(is_file & dest_w);
   wire upd_sub = exec_w & is_sub;
   wire upd_z = exec_w & (is_sub | is_xor);

   // ******************************************************
   // accumulator and flags
   // ******************************************************
   assign acc_d = wr_acc ? wb_dat_i[7:0] : (to_acc ? res_w : acc_q);
   assign c_d = wr_st ? wb_dat_i[`SXS_ST_C] :
                (upd_sub ? (acc_q <= opnd_w) : c_q);
   assign dc_d = wr_st ? wb_dat_i[`SXS_ST_DC] :
                 (upd_sub ? (acc_q[3:0] <= opnd_w[3:0]) : dc_q);
   assign z_d = wr_st ? wb_dat_i[`SXS_ST_Z] :
                (upd_z ? (res_w == 8'h00) : z_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= `SXS_ACC_RST;
         c_q <= 1'b0;
         dc_q <= 1'b0;
         z_q <= 1'b0;
         cmd_q <= `SXS_CMD_RST;
         st_q <= ST_IDLE;
      end else begin
         acc_q <= acc_d;
         c_q <= c_d;
         dc_q <= dc_d;
         z_q <= z_d;
         if (wr_cmd) begin
            cmd_q <= wb_dat_i[`SXS_CMD_W-1:0];
         end
         st_q <= st_d;
      end
   end

   // ******************************************************
   // sequencer: fetch file operand, then execute
   // ******************************************************
   always_comb begin
      case (st_q)
         ST_IDLE: st_d = wr_cmd ? ST_FETCH : ST_IDLE;
         ST_FETCH: st_d = ST_EXEC;
         ST_EXEC: st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   // bus owns the port when idle, the sequencer otherwise
   wire m_we = to_file | wr_mem;
   wire [`SXS_FILE_AW-1:0] m_adr = (st_q == ST_IDLE) ? wb_adr_i[8:2] : fadr_w;
   wire [7:0] m_wd = to_file ? res_w : wb_dat_i[7:0];

   sxs_file_ram u_ram (
      .clk_i(clk_i),
      .we_i(m_we),
      .adr_i(m_adr),
      .wdat_i(m_wd),
      .rdat_o(mem_rdat)
   );

   // ******************************************************
   // checks
   // ******************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_run;
      (st_q == ST_FETCH) ##1 (st_q == ST_EXEC) ##1 (st_q == ST_IDLE);
   endsequence
   property p_run;
      wr_cmd |=> s_run;
   endproperty
   a_run: assert property (p_run) else $error("operation sequence broken");

   property p_ack;
      req_w |=> pend_q ##1 wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack timing wrong");

   property p_sub_lit;
      exec_w && op_w == OP_SUB_ACC_FROM_LITERAL
         |=> acc_q == $past(cmd_q[7:0]) - $past(acc_q);
   endproperty
   a_sub_lit: assert property (p_sub_lit)
      else $error("literal sub wrong");

   property p_carry;
      upd_sub |=> c_q == ($past(acc_q) <= $past(opnd_w)) &&
                  dc_q == ($past(acc_q[3:0]) <= $past(opnd_w[3:0]));
   endproperty
   a_carry: assert property (p_carry) else $error("carry flags wrong");

   property p_sub_file;
      exec_w && op_w == OP_SUB_ACC_FROM_FILE && !dest_w
         |=> acc_q == $past(mem_rdat) - $past(acc_q);
   endproperty
   a_sub_file: assert property (p_sub_file)
      else $error("file sub wrong");

   property p_dest;
      exec_w && is_file && dest_w
         |-> m_we && m_adr == fadr_w ##1 $stable(acc_q);
   endproperty
   a_dest: assert property (p_dest) else $error("destination wrong");

   property p_xor_file;
      exec_w && op_w == OP_XOR_ACC_WITH_FILE
         |=> $stable(c_q) && $stable(dc_q);
   endproperty
   a_xor_file: assert property (p_xor_file)
      else $error("xor touched carry");

   property p_swap;
      exec_w && is_swp && dest_w |-> m_wd == {mem_rdat[3:0], mem_rdat[7:4]}
         ##1 $stable({c_q, dc_q, z_q});
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");

   property p_xor_lit;
      exec_w && op_w == OP_XOR_LITERAL_INTO_ACC
         |=> acc_q == ($past(acc_q) ^ $past(cmd_q[7:0])) && $stable(c_q);
   endproperty
   a_xor_lit: assert property (p_xor_lit)
      else $error("literal xor wrong");

   property p_zero;
      upd_z |=> z_q == ($past(res_w) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule

// >>> sxs_host.sv
`timescale 1ns/1ps
// ******************************************************
// bus master standing in for the decoder side
// ******************************************************
module sxs_host (
   input wire logic clk_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [11:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   int tmo_cnt;
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 12'h000;
      sel_o = 4'hF;
      dat_o = 32'h0;
      tmo_cnt = 0;
   end
   // one classic cycle; ack waits through busy, so no fixed latency
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 200);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      if (n >= 200) tmo_cnt++;
   endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "sxs_defs.svh"
module tb_top;
   import sxs_pkg::*;
   logic clk_i;
   logic rst_i;
   logic cyc, stb, we, ack, busy;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   int err_total;
   int num_checks;
   sxs_alu_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy));
   sxs_host host_u (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack),
      .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ******************************************************
   // checking and closing
   // ******************************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q);
      host_u.xfer(w, a, d, q);
      if (host_u.tmo_cnt != 0) begin
         err_total++;
         end_of_test();
      end
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   // ******************************************************
   // one operation: preload, run, compare acc, file, flags
   // ******************************************************
   task automatic do_op(input logic [2:0] op, input logic dst,
         input logic [7:0] k, input logic [7:0] a0, input logic [7:0] f0,
         input logic [2:0] s0);
      logic [31:0] q;
      logic [11:0] fa;
      logic [7:0] opnd, res;
      logic [2:0] st;
      logic lit, to_f;
      fa = 12'h200 + {3'h0, k[6:0], 2'h0};
      lit = (op == OP_SUB_ACC_FROM_LITERAL) || (op == OP_XOR_LITERAL_INTO_ACC);
      opnd = lit ? k : f0;
      st = s0;
      case (op)
         OP_SUB_ACC_FROM_LITERAL, OP_SUB_ACC_FROM_FILE: begin
            res = opnd - a0;
            st[0] = a0 <= opnd;
            st[1] = a0[3:0] <= opnd[3:0];
         end
         OP_XOR_ACC_WITH_FILE, OP_XOR_LITERAL_INTO_ACC: res = a0 ^ opnd;
         OP_NIBBLE_EXCHANGE_FILE: res = {opnd[3:0], opnd[7:4]};
         default: res = a0;
      endcase
      // swap and reserved codes leave zero alone
      if (op != OP_NIBBLE_EXCHANGE_FILE && op < 3'h5) st[2] = res == 8'h00;
      // literal forms ignore the destination bit
      to_f = dst && !lit && op < 3'h4;
      bus(1'b1, `SXS_ADR_ACC, {24'h0, a0}, q);
      bus(1'b1, fa, {24'h0, f0}, q);
      bus(1'b1, `SXS_ADR_STATUS, {29'h0, s0}, q);
      bus(1'b1, `SXS_ADR_CMD, {20'h0, dst, op, k}, q);
      // busy settles after the commit edge; the next read is held off
      @(negedge clk_i);
      chk({31'h0, busy}, 32'h1);
      rd_chk(`SXS_ADR_ACC, {24'h0, to_f ? a0 : res});
      rd_chk(fa, {24'h0, to_f ? res : f0});
      rd_chk(`SXS_ADR_STATUS, {29'h0, st});
      $display("test op %0d dest %0d done", op, dst);
   endtask
   // ******************************************************
   // main sequence
   // ******************************************************
   initial begin
      rst_i = 1'b1;
      err_total = 0;
      num_checks = 0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(`SXS_ADR_ACC, 32'h0);
      rd_chk(`SXS_ADR_STATUS, 32'h0);
      rd_chk(12'h100, 32'h0);
      $display("test reset done");
      do_op(3'h0, 1'b0, 8'h05, 8'h05, 8'h00, 3'h0);
      do_op(3'h0, 1'b0, 8'h10, 8'h01, 8'h00, 3'h4);
      do_op(3'h0, 1'b0, 8'h00, 8'hFF, 8'h00, 3'h3);
      do_op(3'h1, 1'b0, 8'h10, 8'h31, 8'h30, 3'h4);
      do_op(3'h1, 1'b1, 8'h7F, 8'h0F, 8'hF0, 3'h0);
      do_op(3'h2, 1'b0, 8'h22, 8'hA5, 8'hA5, 3'h3);
      do_op(3'h2, 1'b1, 8'h00, 8'h0F, 8'h3C, 3'h7);
      do_op(3'h3, 1'b1, 8'h40, 8'h00, 8'h9C, 3'h7);
      do_op(3'h3, 1'b0, 8'h41, 8'h55, 8'h5A, 3'h0);
      do_op(3'h4, 1'b1, 8'hFF, 8'hFF, 8'h12, 3'h3);
      do_op(3'h4, 1'b0, 8'h81, 8'h18, 8'h00, 3'h4);
      do_op(3'h5, 1'b1, 8'h33, 8'h77, 8'h66, 3'h5);
      end_of_test();
   end
endmodule
